/* bai_pkg.sv */
/*
 * bai_pkg: shared constants, types and decode helpers for the jump and
 * increment decoder. Assumes 16-bit program words and an 8-bit datapath.
 */
package bai_pkg;

    // opcode fields
    localparam logic [7:0]  JUMP_OP      = 8'hEF;
    localparam logic [3:0]  JUMP2_OP     = 4'hF;
    localparam logic [5:0]  INCR_OP      = 6'h0A;
    localparam int          DEST_BIT     = 9;
    localparam int          BANK_BIT     = 8;
    localparam logic [3:0]  ACCESS_BANK  = 4'h0;

    // quarter phases of one instruction cycle
    localparam logic [1:0]  Q1           = 2'h0;
    localparam logic [1:0]  Q2           = 2'h1;
    localparam logic [1:0]  Q3           = 2'h2;
    localparam logic [1:0]  Q4           = 2'h3;

    // register byte offsets
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_BANK    = 8'h04;
    localparam logic [7:0]  ADDR_WREG    = 8'h08;
    localparam logic [7:0]  ADDR_STATUS  = 8'h0C;
    localparam logic [7:0]  ADDR_PROG    = 8'h10;

    // status flag positions
    localparam int          FLAG_C       = 0;
    localparam int          FLAG_DIGIT   = 1;
    localparam int          FLAG_Z       = 2;
    localparam int          FLAG_OVF     = 3;
    localparam int          FLAG_N       = 4;

    // reset values and program counter step
    localparam logic        RST_RUN      = 1'b0;
    localparam logic [3:0]  RST_BANK     = 4'h0;
    localparam logic [7:0]  RST_WREG     = 8'h00;
    localparam logic [4:0]  RST_STATUS   = 5'h00;
    localparam logic [20:0] RST_PROG     = 21'h000000;
    localparam logic [20:0] PROG_STEP    = 21'h000002;

    typedef enum logic [2:0] {
        ST_READY,
        ST_JUMP,
        ST_SECOND,
        ST_INCR,
        ST_OTHER
    } bai_state_t;

    function automatic logic is_jump(input logic [15:0] w);
        return w[15:8] == JUMP_OP;
    endfunction

    function automatic logic is_jump2(input logic [15:0] w);
        return w[15:12] == JUMP2_OP;
    endfunction

    function automatic logic is_incr(input logic [15:0] w);
        return w[15:10] == INCR_OP;
    endfunction

    function automatic logic [11:0] reg_addr(input logic       a,
                                              input logic [3:0] bank,
                                              input logic [7:0] f);
        return a ? {bank, f} : {ACCESS_BANK, f};
    endfunction

endpackage

/* bai_inc8.sv */
/*
 * bai_inc8: combinational 8-bit add of one with the arithmetic flags.
 * Assumes the caller registers the results at the write quarter.
 */
`timescale 1ns/10ps
module bai_inc8 (
    input  wire logic [7:0] operand,
    output logic      [7:0] sum,
    output logic            carry,
    output logic            digit_carry_flag,
    output logic            zero,
    output logic            negative,
    output logic            overflow_flag
);
    logic [8:0] wide;

    always_comb begin
        wide             = {1'b0, operand} + 9'h001;
        sum              = wide[7:0];
        carry            = wide[8];
        digit_carry_flag = (operand[3:0] == 4'hF);
        zero             = (wide[7:0] == 8'h00);
        negative         = wide[7];
        // adding a positive one overflows only from the largest positive value
        overflow_flag    = !operand[7] && wide[7];
    end
endmodule

/* bai_decoder.sv */
/*
 * bai_decoder: executes the absolute jump and the register increment,
 * with control and state registers on an AHB-Lite slave.
 * Assumes a fetch unit presenting the current and following program words,
 * and a data memory whose read data is valid in the same clock as the read strobe.
 */
// Overview of operation
// - the jump takes a 20-bit target from 0 to 1048575 built from its two words.
// - the jump writes the target into program counter bits 20:1 and keeps bit 0 at zero.
// - the jump first word has top byte 1110 1111 with target bits 7:0, the second top nibble 1111 with bits 19:8.
// - the jump uses two words and two instruction cycles, the second doing nothing.
// - the jump reaches all of the 2 Mbyte program space regardless of the current program counter.
// - the increment reads the addressed register, adds one and sends the sum to the destination.
// - with destination bit 0 the sum goes to the working register and memory is untouched.
// - with destination bit 1 the sum is written back to the register it was read from.
// - with bank bit 0 the register sits in the fixed access bank and the bank select register is ignored.
// - with bank bit 1 the register address uses the bank select register.
// - the increment is one word: opcode 0010 10, destination bit, bank bit, 8-bit register address.
// - the increment updates carry, digit carry, negative, overflow and zero; the jump changes no flag.
`timescale 1ns/10ps
module bai_decoder
    import bai_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        fetch_valid,
    input  wire logic [15:0] fetch_word,
    input  wire logic [15:0] fetch_word2,
    output logic             fetch_taken,
    output logic             fetch_two,
    output logic      [20:0] program_counter,
    output logic      [11:0] dmem_addr,
    output logic             dmem_re,
    input  wire logic [7:0]  dmem_rdata,
    output logic             dmem_we,
    output logic      [7:0]  dmem_wdata,
    output logic      [7:0]  working_reg,
    output logic      [4:0]  status_flags,
    output logic      [1:0]  q_phase
);

    bai_state_t  state;
    logic        ctrl_run;
    logic [3:0]  bank_select_register;
    logic [15:0] ir;
    logic [15:0] ir2;
    logic [7:0]  k_lo;
    logic [7:0]  operand;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        sw_wreg_wr;
    logic        sw_status_wr;
    logic        addr_phase;
    logic        q4_incr;
    logic [7:0]  inc_sum;
    logic        inc_c;
    logic        inc_digit;
    logic        inc_z;
    logic        inc_n;
    logic        inc_ovf;
    logic [4:0]  next_flags;

    bai_inc8 u_inc (
        .operand          (operand),
        .sum              (inc_sum),
        .carry            (inc_c),
        .digit_carry_flag (inc_digit),
        .zero             (inc_z),
        .negative         (inc_n),
        .overflow_flag    (inc_ovf)
    );

    assign addr_phase   = hsel && htrans[1] && hready;
    assign sw_wreg_wr   = wr_pend && (wr_addr == ADDR_WREG);
    assign sw_status_wr = wr_pend && (wr_addr == ADDR_STATUS);
    assign q4_incr      = ctrl_run && (state == ST_INCR) && (q_phase == Q4);

    always_comb begin
        next_flags          = status_flags;
        next_flags[FLAG_C]  = inc_c;
        next_flags[FLAG_DIGIT] = inc_digit;
        next_flags[FLAG_Z]     = inc_z;
        next_flags[FLAG_N]     = inc_n;
        next_flags[FLAG_OVF]   = inc_ovf;
    end

    // bus slave: zero wait states, read data registered in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_phase && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_phase && !hwrite) begin
            unique case (haddr[7:0])
                ADDR_CTRL:   hrdata <= {31'h00000000, ctrl_run};
                ADDR_BANK:   hrdata <= {28'h0000000, bank_select_register};
                ADDR_WREG:   hrdata <= {24'h000000, working_reg};
                ADDR_STATUS: hrdata <= {27'h0000000, status_flags};
                ADDR_PROG:   hrdata <= {11'h000, program_counter};
                default:     hrdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_run <= RST_RUN;
        end else if (wr_pend && (wr_addr == ADDR_CTRL)) begin
            ctrl_run <= hwdata[0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bank_select_register <= RST_BANK;
        end else if (wr_pend && (wr_addr == ADDR_BANK)) begin
            bank_select_register <= hwdata[3:0];
        end
    end

    // quarter phase divider, frozen while stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_phase <= Q1;
        end else if (ctrl_run) begin
            q_phase <= q_phase + 2'h1;
        end
    end

    // instruction sequencing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state       <= ST_READY;
            ir          <= 16'h0000;
            ir2         <= 16'h0000;
            fetch_taken <= 1'b0;
            fetch_two   <= 1'b0;
        end else begin
            fetch_taken <= 1'b0;
            fetch_two   <= 1'b0;
            if (ctrl_run && (q_phase == Q1) && (state == ST_READY) && fetch_valid) begin
                fetch_taken <= 1'b1;
                ir          <= fetch_word;
                ir2         <= fetch_word2;
                // a first word without a valid second word is not taken as a jump
                if (is_jump(fetch_word) && is_jump2(fetch_word2)) begin
                    state     <= ST_JUMP;
                    fetch_two <= 1'b1;
                end else if (is_incr(fetch_word)) begin
                    state <= ST_INCR;
                end else begin
                    state <= ST_OTHER;
                end
            end else if (ctrl_run && (q_phase == Q4)) begin
                unique case (state)
                    ST_JUMP:   state <= ST_SECOND;
                    ST_SECOND: state <= ST_READY;
                    ST_INCR:   state <= ST_READY;
                    ST_OTHER:  state <= ST_READY;
                    ST_READY:  state <= ST_READY;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            k_lo <= 8'h00;
        end else if (ctrl_run && (state == ST_JUMP) && (q_phase == Q2)) begin
            k_lo <= ir[7:0];
        end
    end

    // absolute target: no add to the old value, so all of the space is reachable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            program_counter <= RST_PROG;
        end else if (ctrl_run && (q_phase == Q4)) begin
            if (state == ST_JUMP) begin
                program_counter <= {ir2[11:0], k_lo, 1'b0};
            end else if ((state == ST_INCR) || (state == ST_OTHER)) begin
                program_counter <= program_counter + PROG_STEP;
            end
        end
    end

    // data memory side of the increment
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dmem_addr <= 12'h000;
            dmem_re   <= 1'b0;
        end else begin
            dmem_re <= 1'b0;
            if (ctrl_run && (state == ST_INCR) && (q_phase == Q2)) begin
                dmem_addr <= reg_addr(ir[BANK_BIT], bank_select_register, ir[7:0]);
                dmem_re   <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            operand <= 8'h00;
        end else if (ctrl_run && (state == ST_INCR) && (q_phase == Q3)) begin
            operand <= dmem_rdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dmem_we    <= 1'b0;
            dmem_wdata <= 8'h00;
        end else begin
            dmem_we <= 1'b0;
            if (q4_incr && ir[DEST_BIT]) begin
                dmem_we    <= 1'b1;
                dmem_wdata <= inc_sum;
            end
        end
    end

    // the core write wins over a software write landing in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            working_reg <= RST_WREG;
        end else if (q4_incr && !ir[DEST_BIT]) begin
            working_reg <= inc_sum;
        end else if (sw_wreg_wr) begin
            working_reg <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_flags <= RST_STATUS;
        end else if (q4_incr) begin
            status_flags <= next_flags;
        end else if (sw_status_wr) begin
            status_flags <= hwdata[4:0];
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence jump_load;
        ctrl_run && (state == ST_JUMP) && (q_phase == Q4);
    endsequence

    sequence incr_start;
        fetch_taken && ctrl_run && (state == ST_INCR);
    endsequence

    sequence incr_write;
        q4_incr;
    endsequence

    chk_jump_target_load: assert property (jump_load |=> program_counter == {$past(ir2[11:0]), $past(k_lo), 1'b0})
        else $error("jump target not loaded into program counter");

    chk_counter_bit_zero: assert property (program_counter[0] == 1'b0)
        else $error("program counter bit 0 is set");

    chk_jump_decode: assert property (fetch_taken && is_jump(ir) && is_jump2(ir2) |-> (state == ST_JUMP) && fetch_two)
        else $error("jump word pair not decoded");

    chk_jump_idle_cycle: assert property (jump_load |=> (state == ST_SECOND && !dmem_we && !dmem_re && !fetch_taken)[*4])
        else $error("second jump cycle was not idle");

    chk_jump_flags_kept: assert property ((state == ST_JUMP) && !sw_status_wr |=> $stable(status_flags))
        else $error("jump changed the flags");

    chk_incr_decode: assert property (fetch_taken && is_incr(ir) |-> state == ST_INCR)
        else $error("increment word not decoded");

    chk_incr_bank_addr: assert property (ctrl_run && (state == ST_INCR) && (q_phase == Q2)
        |=> dmem_re && (dmem_addr == reg_addr($past(ir[BANK_BIT]), $past(bank_select_register), $past(ir[7:0]))))
        else $error("increment register address wrong");

    // a bus write to the working register in the same cycle may move it, so leave that case out
    chk_incr_mem_write: assert property (q4_incr && ir[DEST_BIT] && !sw_wreg_wr
        |=> dmem_we && (dmem_wdata == $past(operand) + 8'h01) && $stable(working_reg))
        else $error("increment write back to memory wrong");

    chk_incr_wreg_write: assert property (q4_incr && !ir[DEST_BIT]
        |=> !dmem_we && (working_reg == $past(operand) + 8'h01))
        else $error("increment result not in working register");

    chk_incr_flag_zero: assert property (q4_incr
        |=> (status_flags[FLAG_Z] == ($past(operand) == 8'hFF)) && (status_flags[FLAG_C] == status_flags[FLAG_Z]))
        else $error("increment zero or carry flag wrong");

    chk_incr_one_cycle: assert property ((incr_start ##1 ctrl_run[*2]) |=> state == ST_READY)
        else $error("increment did not end in one cycle");

    chk_jump_low_byte: assert property (ctrl_run && (state == ST_JUMP) && (q_phase == Q2)
        |=> k_lo == $past(ir[7:0]))
        else $error("jump low target byte not latched");

    chk_fetch_refused: assert property (fetch_taken
        |-> ($past(state) == ST_READY) && ($past(q_phase) == Q1) && $past(fetch_valid) && $past(ctrl_run))
        else $error("fetch taken outside the decode quarter");

    chk_incr_operand: assert property (ctrl_run && (state == ST_INCR) && (q_phase == Q3)
        |=> operand == $past(dmem_rdata))
        else $error("increment operand not taken from memory");

    chk_incr_flag_arith: assert property (incr_write
        |=> (status_flags[FLAG_DIGIT] == ($past(operand[3:0]) == 4'hF))
            && (status_flags[FLAG_OVF] == ($past(operand) == 8'h7F))
            && (status_flags[FLAG_N] == (($past(operand) >= 8'h7F) && ($past(operand) != 8'hFF))))
        else $error("increment digit carry, overflow or negative flag wrong");

    chk_word_step: assert property (ctrl_run && (q_phase == Q4)
        && ((state == ST_INCR) || (state == ST_OTHER))
        |=> program_counter == $past(program_counter) + PROG_STEP)
        else $error("program counter did not step by one word");

    chk_incr_one_word: assert property (fetch_taken && is_incr(ir) |-> !fetch_two)
        else $error("increment consumed two words");

endmodule

/* bai_dmem_model.sv */
/*
 * bai_dmem_model: byte-wide data memory standing behind the decoder.
 * Assumes the read strobe and address stand together for one clock.
 */
`timescale 1ns/10ps
module bai_dmem_model (
    input  wire logic        hclk,
    input  wire logic [11:0] dmem_addr,
    input  wire logic        dmem_re,
    input  wire logic        dmem_we,
    input  wire logic [7:0]  dmem_wdata,
    output logic      [7:0]  dmem_rdata
);
    logic [7:0] mem [0:4095];
    logic [7:0] junk = 8'hA5;
    // outside a read the bus toggles, so a late or early sample never matches by luck
    // plain always: the bench preloads the array directly between strobes
    always @(posedge hclk) begin
        junk <= ~junk;
        if (dmem_we) begin
            mem[dmem_addr] <= dmem_wdata;
        end
    end
    assign dmem_rdata = dmem_re ? mem[dmem_addr] : junk;
endmodule

/* tb_branch_and_increment_decode.sv */
/*
 * tb_branch_and_increment_decode: self-checking bench for the jump and
 * increment decoder. Assumes one AHB-Lite slave and the memory model above.
 */
`timescale 1ns/10ps
module tb_branch_and_increment_decode
    import bai_pkg::*;
();
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [31:0] hwdata  = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic [2:0]  hsize   = 3'h2;
    logic        fetch_valid = 1'b0;
    logic [15:0] fetch_word  = 16'h0;
    logic [15:0] fetch_word2 = 16'h0;
    logic        hready, hreadyout, hresp, fetch_taken, fetch_two, dmem_re, dmem_we, tw, we_seen;
    logic [31:0] hrdata, rd;
    logic [20:0] program_counter, prog_start;
    logic [11:0] dmem_addr, re_addr, ea;
    logic [7:0]  dmem_rdata, dmem_wdata, working_reg;
    logic [4:0]  status_flags;
    logic [1:0]  q_phase, re_q;
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          n;
    typedef struct packed {
        logic       d;
        logic       a;
        logic [3:0] bank;
        logic [7:0] f;
        logic [7:0] v;
        logic [7:0] sum;
        logic [4:0] flags;
    } bai_row_t;
    bai_row_t    r;
    localparam bai_row_t ROWS [4] = '{
        '{1'b1, 1'b0, 4'h6, 8'h10, 8'hFF, 8'h00, 5'h07},
        '{1'b0, 1'b1, 4'h3, 8'h20, 8'h7F, 8'h80, 5'h1A},
        '{1'b1, 1'b1, 4'hF, 8'hFF, 8'h0F, 8'h10, 5'h02},
        '{1'b0, 1'b0, 4'h5, 8'h00, 8'h41, 8'h42, 5'h00}
    };
    localparam logic [19:0] JT [2] = '{20'hFFFFF, 20'h00001};
    assign hready = hreadyout;

    bai_decoder u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .fetch_valid(fetch_valid), .fetch_word(fetch_word), .fetch_word2(fetch_word2),
        .fetch_taken(fetch_taken), .fetch_two(fetch_two), .program_counter(program_counter),
        .dmem_addr(dmem_addr), .dmem_re(dmem_re), .dmem_rdata(dmem_rdata), .dmem_we(dmem_we),
        .dmem_wdata(dmem_wdata), .working_reg(working_reg), .status_flags(status_flags), .q_phase(q_phase)
    );
    bai_dmem_model u_mem (
        .hclk(hclk), .dmem_addr(dmem_addr), .dmem_re(dmem_re), .dmem_we(dmem_we),
        .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata)
    );

    initial begin
        forever #2 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // hold keeps the fetch request up after it is taken, to probe refusals
    task automatic exec(input logic [15:0] w1, input logic [15:0] w2, input logic hold);
        @(posedge hclk);
        fetch_word  <= w1;
        fetch_word2 <= w2;
        fetch_valid <= 1'b1;
        do @(negedge hclk); while (fetch_taken !== 1'b1);
        tw = fetch_two;
        we_seen = 1'b0;
        re_q = 2'h0;
        @(posedge hclk);
        fetch_valid <= hold;
        do begin
            @(negedge hclk);
            if (dmem_re === 1'b1) begin
                re_q = q_phase;
                re_addr = dmem_addr;
            end
            if (dmem_we === 1'b1) begin
                we_seen = 1'b1;
            end
        end while (q_phase !== 2'h0);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge hclk);
        chk("bus during reset", 32'h1, {30'h0, hresp, hreadyout});
        hresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            chk("reset or unmapped read", 32'h0, rd);
        end
        bus(1'b1, ADDR_WREG, 32'h0000005A);
        bus(1'b0, ADDR_WREG, 32'h0);
        chk("wreg readback", 32'h5A, rd);
        bus(1'b1, ADDR_PROG, 32'h00001234);
        bus(1'b0, ADDR_PROG, 32'h0);
        chk("counter read only", 32'h0, rd);
        bus(1'b1, ADDR_CTRL, 32'h1);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            ea = {r.a ? r.bank : ACCESS_BANK, r.f};
            u_mem.mem[{r.bank, r.f}] = 8'h99;
            u_mem.mem[ea] = r.v;
            bus(1'b1, ADDR_BANK, {28'h0, r.bank});
            bus(1'b1, ADDR_WREG, 32'h000000C3);
            bus(1'b1, ADDR_STATUS, 32'h0);
            prog_start = program_counter;
            exec({INCR_OP, r.d, r.a, r.f}, 16'h0000, 1'b0);
            // the memory write lands one edge after the strobe
            @(negedge hclk);
            chk("read address", {20'h0, ea}, {20'h0, re_addr});
            chk("read quarter", 32'h2, {30'h0, re_q});
            chk("write strobe", {31'h0, r.d}, {31'h0, we_seen});
            chk("memory", {24'h0, r.d ? r.sum : r.v}, {24'h0, u_mem.mem[ea]});
            chk("wreg", {24'h0, r.d ? 8'hC3 : r.sum}, {24'h0, working_reg});
            chk("flags", {27'h0, r.flags}, {27'h0, status_flags});
            chk("counter step", {11'h0, prog_start + PROG_STEP}, {11'h0, program_counter});
            chk("one word", 32'h0, {31'h0, tw});
        end
        bus(1'b0, ADDR_BANK, 32'h0);
        chk("bank readback", {28'h0, ROWS[3].bank}, rd);
        bus(1'b1, ADDR_STATUS, 32'h0000001F);
        foreach (JT[j]) begin
            exec({JUMP_OP, JT[j][7:0]}, {JUMP2_OP, JT[j][19:8]}, 1'b0);
            chk("jump counter", {11'h0, JT[j], 1'b0}, {11'h0, program_counter});
            chk("two words", 32'h1, {31'h0, tw});
            chk("jump flags", 32'h1F, {27'h0, status_flags});
        end
        bus(1'b0, ADDR_PROG, 32'h0);
        chk("counter readback", {11'h0, JT[1], 1'b0}, rd);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("status readback", 32'h1F, rd);
        exec({JUMP_OP, 8'h34}, {JUMP2_OP, 12'h012}, 1'b1);
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (fetch_taken !== 1'b1 && n < 20);
        chk("idle second cycle", 32'd5, 32'(n));
        @(posedge hclk);
        fetch_valid <= 1'b0;
        do @(negedge hclk); while (q_phase !== 2'h0);
        chk("jump counter mid", {11'h0, 20'h01234, 1'b0}, {11'h0, program_counter});
        prog_start = program_counter;
        exec({JUMP_OP, 8'h12}, 16'h0345, 1'b0);
        chk("not a jump", {11'h0, prog_start + PROG_STEP}, {11'h0, program_counter});
        chk("not two words", 32'h0, {31'h0, tw});
        // second reset in mid-run: core state must fall back and the core must stay stopped
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        chk("reset counter", 32'h0, {11'h0, program_counter});
        chk("reset core", 32'h0, {17'h0, working_reg, status_flags, q_phase});
        hresetn <= 1'b1;
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk("run after reset", 32'h0, rd);
        print_verdict();
    end
endmodule
